// *** design/cod_channel.sv ***
// channel output driver control: registers, transfer strobe and pair a drivers
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
module cod_channel #(
    parameter int div_width = 8
) (
    input  wire logic                 clk,
    input  wire logic                 arst_n,
    input  wire logic [15:0]          addr,
    input  wire logic [7:0]           wdata,
    input  wire logic                 wr_en,
    input  wire logic                 rd_en,
    output logic [7:0]                rdata,
    input  wire logic [div_width-1:0] half_period,
    input  wire logic                 diff_mode,
    output logic                      nshot_pulse,
    output logic                      output_a_positive_pin_o,
    output logic                      output_a_positive_pin_oe_n,
    output logic                      output_a_negative_pin_o,
    output logic                      output_a_negative_pin_oe_n
);
    // buffered (written) and active (applied) register copies
    logic [7:0] chan_buf;
    logic [7:0] chan_act;
    logic [7:0] pair_buf;
    logic [7:0] pair_act;
    logic       nshot_prev;
    logic [7:0] next_rdata;

    // address match against one register offset
    function automatic logic hits(
        input logic [15:0] at,
        input logic [15:0] target
    );
        return (at == target);
    endfunction : hits

    // address decode
    logic sel_chan;
    logic sel_pair;
    logic sel_update;
    logic wr_chan;
    logic wr_pair;
    logic do_update;
    assign sel_chan   = hits(addr, cod_pkg::chan_ctrl_addr);
    assign sel_pair   = hits(addr, cod_pkg::pair_a_ctrl_addr);
    assign sel_update = hits(addr, cod_pkg::update_addr);

    // write strobes per register; unmapped writes reach nothing
    assign wr_chan    = wr_en & sel_chan;
    assign wr_pair    = wr_en & sel_pair;
    assign do_update  = wr_en & sel_update & wdata[cod_pkg::update_bit];

    // channel buffer, reserved bits masked off
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            chan_buf <= cod_pkg::chan_ctrl_rst;
        end else if (wr_chan) begin
            chan_buf <= wdata & cod_pkg::chan_ctrl_mask;
        end
    end

    // pair a buffer, reserved bits masked off
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pair_buf <= cod_pkg::pair_a_ctrl_rst;
        end else if (wr_pair) begin
            pair_buf <= wdata & cod_pkg::pair_a_ctrl_mask;
        end
    end

    // transfer strobe copies the channel buffer into the active set
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            chan_act <= cod_pkg::chan_ctrl_rst;
        end else if (do_update) begin
            chan_act <= chan_buf;
        end
    end

    // transfer strobe copies the pair a buffer into the active set
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pair_act <= cod_pkg::pair_a_ctrl_rst;
        end else if (do_update) begin
            pair_act <= pair_buf;
        end
    end

    // n-shot request acts on a rising active value after the strobe
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            nshot_prev  <= 1'b0;
            nshot_pulse <= 1'b0;
        end else begin
            nshot_prev  <= chan_act[cod_pkg::nshot_bit];
            nshot_pulse <= chan_act[cod_pkg::nshot_bit] & ~nshot_prev;
        end
    end

    // read mux: software sees buffered values, zero elsewhere
    assign next_rdata = !rd_en   ? 8'h00 :
                        sel_chan ? chan_buf :
                        sel_pair ? pair_buf : 8'h00;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end

    // bit picker for applied register copies, shared by every control decode except the n-shot request
    function automatic logic field_of(
        input logic [7:0] value,
        input int         pos
    );
        return value[pos];
    endfunction : field_of

    // channel-wide controls, taken from the applied copy only
    logic ch_sync;
    logic ch_mute;
    logic ch_rst;
    assign ch_sync = field_of(chan_act, cod_pkg::chan_sync_bit);
    assign ch_mute = field_of(chan_act, cod_pkg::chan_mute_bit);
    assign ch_rst  = field_of(chan_act, cod_pkg::chan_rst_bit);

    // pair a controls, taken from the applied copy only
    logic drv_rst;
    logic pdn;
    logic true_mute_sel;
    logic comp_mute_sel;
    logic true_div_sel;
    logic comp_div_sel;
    assign drv_rst       = field_of(pair_act, cod_pkg::rst_drv_bit);
    assign pdn           = field_of(pair_act, cod_pkg::pdn_bit);
    assign true_mute_sel = field_of(pair_act, cod_pkg::mute_true_bit);
    assign comp_mute_sel = field_of(pair_act, cod_pkg::mute_comp_bit);
    assign true_div_sel  = field_of(pair_act, cod_pkg::rst_div_true_bit);
    assign comp_div_sel  = field_of(pair_act, cod_pkg::rst_div_comp_bit);

    // any channel-wide control that silences both legs
    logic chan_quiet;
    assign chan_quiet = ch_mute | ch_rst | ch_sync;

    // complement mute only counts on a single-ended complement leg
    logic comp_own_mute;
    assign comp_own_mute = comp_mute_sel & ~diff_mode;

    // delayed mute requests settle at a low phase
    logic mute_true_req;
    logic mute_comp_req;
    assign mute_true_req = chan_quiet | true_mute_sel;
    assign mute_comp_req = chan_quiet | comp_own_mute;

    // immediate mutes bypass the safe-point wait
    logic true_now;
    logic comp_now;
    assign true_now = ch_rst | drv_rst;
    assign comp_now = ch_rst | drv_rst;

    // divider reset: sync holds all dividers static, release starts them together
    logic div_true_rst;
    logic div_comp_rst;
    assign div_true_rst = ch_sync | true_div_sel;
    assign div_comp_rst = ch_sync | comp_div_sel;

    logic true_clk;
    logic true_muted;
    logic comp_clk;
    logic comp_muted;

    // true leg divider
    cod_divider #(
        .width       (div_width)
    ) u_div_true (
        .clk         (clk),
        .arst_n      (arst_n),
        .div_reset   (div_true_rst),
        .half_period (half_period),
        .mute_req    (mute_true_req),
        .mute_now    (true_now),
        .clk_out     (true_clk),
        .muted       (true_muted)
    );

    // complement leg divider
    cod_divider #(
        .width       (div_width)
    ) u_div_comp (
        .clk         (clk),
        .arst_n      (arst_n),
        .div_reset   (div_comp_rst),
        .half_period (half_period),
        .mute_req    (mute_comp_req),
        .mute_now    (comp_now),
        .clk_out     (comp_clk),
        .muted       (comp_muted)
    );

    // pin levels: muted differential complement sits high, single-ended sits low
    logic comp_level;
    logic comp_held;
    // registered mute flag only, so both legs change state on the same edge
    assign comp_held  = comp_muted;
    assign comp_level = diff_mode ? (comp_held ? 1'b1 : ~true_clk)
                                  : (comp_held ? 1'b0 : comp_clk);

    // true pin level, registered
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            output_a_positive_pin_o <= 1'b0;
        end else begin
            output_a_positive_pin_o <= true_clk;
        end
    end

    // complement pin level, registered
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            output_a_negative_pin_o <= 1'b0;
        end else begin
            output_a_negative_pin_o <= comp_level;
        end
    end

    // true pin enable: power down alone tristates, mutes keep driving
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            output_a_positive_pin_oe_n <= 1'b0;
        end else begin
            output_a_positive_pin_oe_n <= pdn;
        end
    end

    // complement pin enable: same control as the true pin
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            output_a_negative_pin_oe_n <= 1'b0;
        end else begin
            output_a_negative_pin_oe_n <= pdn;
        end
    end
endmodule : cod_channel

// *** design/cod_divider.sv ***
// one distribution divider with gated output, runt-free except on immediate mute or divider reset
`timescale 1ns/1ps
module cod_divider #(
    parameter int width = 8
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic             div_reset,
    input  wire logic [width-1:0] half_period,
    input  wire logic             mute_req,
    input  wire logic             mute_now,
    output logic                  clk_out,
    output logic                  muted
);
    logic [width-1:0] count;
    logic             phase;
    logic             wrap;
    logic             low_edge;

    // toggle point of the divided clock
    assign wrap     = (count + width'(1)) >= half_period;
    // phase falls at the next toggle: safe point to freeze low
    assign low_edge = wrap & phase;

    // divider counter, held static while reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count <= '0;
            phase <= 1'b0;
        end else if (div_reset) begin
            count <= '0;
            phase <= 1'b0;
        end else if (wrap) begin
            count <= '0;
            phase <= ~phase;
        end else begin
            count <= count + width'(1);
        end
    end

    // gate: immediate mute, otherwise change state only while phase is low, as phase falls, or in divider reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            muted <= 1'b0;
        end else if (mute_now) begin
            muted <= 1'b1;
        end else if (mute_req != muted && (low_edge || (!phase && !wrap) || div_reset)) begin
            muted <= mute_req;
        end
    end

    // registered gated output
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            clk_out <= 1'b0;
        end else if (mute_now || muted) begin
            clk_out <= 1'b0;
        end else if (div_reset) begin
            clk_out <= 1'b0;
        end else begin
            clk_out <= wrap ? ~phase : phase;
        end
    end
endmodule : cod_divider

// *** design/cod_pkg.sv ***
// package: register map, field positions and constants for channel output driver control
package cod_pkg;
    // register offsets (byte addresses as printed)
    localparam logic [15:0] chan_ctrl_addr  = 16'h2101;
    localparam logic [15:0] pair_a_ctrl_addr = 16'h2102;
    localparam logic [15:0] update_addr     = 16'h000f;
    // channel control fields
    localparam int nshot_bit     = 0;
    localparam int chan_mute_bit = 1;
    localparam int chan_rst_bit  = 2;
    localparam int chan_sync_bit = 3;
    localparam logic [7:0] chan_ctrl_mask = 8'h0f;
    // pair a control fields
    localparam int rst_div_true_bit  = 0;
    localparam int rst_div_comp_bit  = 1;
    localparam int mute_true_bit     = 2;
    localparam int mute_comp_bit     = 3;
    localparam int pdn_bit           = 4;
    localparam int rst_drv_bit       = 5;
    localparam logic [7:0] pair_a_ctrl_mask = 8'h3f;
    // transfer strobe field
    localparam int update_bit = 0;
    // reset values
    localparam logic [7:0] chan_ctrl_rst  = 8'h00;
    localparam logic [7:0] pair_a_ctrl_rst = 8'h00;
    localparam logic [7:0] divide_rst     = 8'h02;
endpackage : cod_pkg

// *** verif/cod_channel_monitor.sv ***
// checker of port relations for the channel output driver control
`timescale 1ns/1ps
module cod_channel_monitor #(
    parameter int div_width = 8
) (
    input wire logic                 clk,
    input wire logic                 arst_n,
    input wire logic [15:0]          addr,
    input wire logic [7:0]           wdata,
    input wire logic                 wr_en,
    input wire logic                 rd_en,
    input wire logic [7:0]           rdata,
    input wire logic [div_width-1:0] half_period,
    input wire logic                 diff_mode,
    input wire logic                 nshot_pulse,
    input wire logic                 output_a_positive_pin_o,
    input wire logic                 output_a_positive_pin_oe_n,
    input wire logic                 output_a_negative_pin_o,
    input wire logic                 output_a_negative_pin_oe_n
);
    // true leg enable and a transfer strobe write
    wire pe  = output_a_positive_pin_oe_n;
    wire upd = wr_en && addr == cod_pkg::update_addr && wdata[0];
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_oe_legs_equal: assert property (pe == output_a_negative_pin_oe_n) else $error("enables differ");
    a_rdata_idle: assert property (!$past(rd_en) |-> rdata == 8'h00) else $error("stray rdata");
    a_rdata_unmapped: assert property ($past(rd_en) && $past(addr) > cod_pkg::pair_a_ctrl_addr
        |-> rdata == 8'h00) else $error("unmapped read not zero");
    a_reserved_zero: assert property ($past(rd_en) |-> rdata[7:6] == 2'b00) else $error("reserved set");
    a_nshot_single: assert property (nshot_pulse |=> !nshot_pulse) else $error("long n-shot pulse");
    a_nshot_cause: assert property ($rose(nshot_pulse) |-> $past(upd) || $past(upd, 2))
        else $error("n-shot without transfer");
    a_oe_on_update: assert property ($changed(pe) |-> $past(upd) || $past(upd, 2) || $past(upd, 3))
        else $error("enable moved without transfer");
    a_diff_legs: assert property (diff_mode && $past(diff_mode, 4) && $past(arst_n, 4) && !pe
        |-> output_a_negative_pin_o != output_a_positive_pin_o) else $error("legs not complementary");
endmodule : cod_channel_monitor

// *** verif/cod_channel_tb.sv ***
// self-checking bench for the channel output driver control
`timescale 1ns/1ps
module cod_channel_tb;
    logic        clk = 1'b0, arst_n = 1'b0, we = 1'b0, re = 1'b0, dm = 1'b1, shot, p, pe, n, ne;
    logic [15:0] a = 16'h0000;
    logic [7:0]  d = 8'h00, rdata;
    int          failures = 0, cmp_count = 0, shots = 0, runts, runts_n;
    wire  [3:0]  pins = {ne, pe, n, p};
    // device and clock sinks on the true and complement pins
    cod_channel cod_channel_i (.clk(clk), .arst_n(arst_n), .addr(a), .wdata(d), .wr_en(we), .rd_en(re),
        .rdata(rdata), .half_period(8'h02), .diff_mode(dm), .nshot_pulse(shot), .output_a_positive_pin_o(p),
        .output_a_positive_pin_oe_n(pe), .output_a_negative_pin_o(n), .output_a_negative_pin_oe_n(ne));
    cod_clock_sink cod_clock_sink_i (.clk(clk), .pin(p), .oe_n(pe), .min_high(8'h02), .runts(runts));
    cod_clock_sink cod_clock_sink_i2 (.clk(clk), .pin(n), .oe_n(ne), .min_high(8'h02), .runts(runts_n));
    // clock and n-shot pulse count
    always #25 clk = ~clk;
    always @(posedge clk) if (shot === 1'b1) shots++;
    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask : cmp
    task automatic finish_test();
        $display("failures %0d compares %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    // one bus cycle: a write, or a read checked in the next cycle
    task automatic bus(input logic w, input logic [15:0] x, input logic [7:0] v);
        a  <= x;
        d  <= v;
        we <= w;
        re <= !w;
        @(posedge clk);
        we <= 1'b0;
        re <= 1'b0;
        #1 if (!w) cmp(rdata, v);
        @(posedge clk);
    endtask : bus
    // set a control, check pins at once and settled, release and check clean toggling
    task automatic scen(input logic s, input logic [7:0] v, input logic [3:0] mi, input logic [3:0] m,
                        input logic [3:0] e);
        int c;
        int r;
        int rn;
        c = 0;
        bus(1'b1, s ? cod_pkg::pair_a_ctrl_addr : cod_pkg::chan_ctrl_addr, v);
        bus(1'b1, cod_pkg::update_addr, 8'h01);
        @(posedge clk);
        #1 cmp({4'h0, pins & mi}, {4'h0, e & mi});
        repeat (8) @(posedge clk);
        #1 cmp({4'h0, pins & m}, {4'h0, e});
        r = runts;
        rn = runts_n;
        @(posedge clk);
        bus(1'b1, s ? cod_pkg::pair_a_ctrl_addr : cod_pkg::chan_ctrl_addr, 8'h00);
        bus(1'b1, cod_pkg::update_addr, 8'h01);
        repeat (8) @(posedge clk);
        repeat (12) begin
            @(posedge clk);
            #1 c += int'(p === 1'b1);
        end
        cmp(8'(c), 8'h06);
        cmp(8'(runts - r), 8'h00);
        cmp(8'(runts_n - rn), 8'h00);
        @(posedge clk);
    endtask : scen
    // registers, reserved bits, unmapped space and the buffered n-shot request
    task automatic t_regs();
        bus(1'b0, cod_pkg::pair_a_ctrl_addr, 8'h00);
        bus(1'b1, cod_pkg::chan_ctrl_addr, 8'hf1);
        bus(1'b0, cod_pkg::chan_ctrl_addr, 8'h01);
        bus(1'b0, 16'h2108, 8'h00);
        cmp(8'(shots), 8'h00);
        bus(1'b1, cod_pkg::update_addr, 8'h01);
        bus(1'b1, cod_pkg::chan_ctrl_addr, 8'h00);
        cmp(8'(shots), 8'h01);
        bus(1'b1, cod_pkg::update_addr, 8'h01);
    endtask : t_regs
    // reset, then the scenarios in turn
    initial begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        t_regs();
        scen(1'b0, 8'h02, 4'h0, 4'hf, 4'h2);
        scen(1'b0, 8'h04, 4'h1, 4'hf, 4'h2);
        scen(1'b1, 8'h04, 4'h0, 4'hf, 4'h2);
        scen(1'b1, 8'h01, 4'h0, 4'hf, 4'h2);
        scen(1'b0, 8'h08, 4'h0, 4'hf, 4'h2);
        scen(1'b1, 8'h10, 4'h0, 4'hc, 4'hc);
        scen(1'b1, 8'h20, 4'h1, 4'hf, 4'h2);
        dm <= 1'b0;
        scen(1'b1, 8'h08, 4'h0, 4'he, 4'h0);
        finish_test();
    end
endmodule : cod_channel_tb
bind cod_channel cod_channel_monitor #(.div_width(div_width)) cod_channel_monitor_i (.clk(clk), .arst_n(arst_n),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .half_period(half_period),
    .diff_mode(diff_mode), .nshot_pulse(nshot_pulse), .output_a_positive_pin_o(output_a_positive_pin_o),
    .output_a_positive_pin_oe_n(output_a_positive_pin_oe_n), .output_a_negative_pin_o(output_a_negative_pin_o),
    .output_a_negative_pin_oe_n(output_a_negative_pin_oe_n));

// *** verif/cod_clock_sink.sv ***
// downstream clock input model: counts high pulses shorter than min_high
`timescale 1ns/1ps
module cod_clock_sink (
    input  wire logic       clk,
    input  wire logic       pin,
    input  wire logic       oe_n,
    input  wire logic [7:0] min_high,
    output int              runts
);
    int   width = 0;
    logic armed = 1'b0;
    // only pulses that start from a driven low are judged
    always @(posedge clk) begin
        if (oe_n !== 1'b0) begin
            armed = 1'b0;
            width = 0;
        end else if (pin === 1'b1)
            width = width + 1;
        else begin
            runts = (armed && width != 0 && width < min_high) ? runts + 1 : runts;
            armed = 1'b1;
            width = 0;
        end
    end
    initial runts = 0;
endmodule : cod_clock_sink
